// ===== rtl/qscr_top.sv
// Behaviour
// - collision bus-error enable makes data-window writes to executing command an error
// - abort bus-error enable makes clearing queue enable mid-transfer an error
// - abort lockout stops register writes from clearing queue enable
// - three enable bits gate collision, abort and finished interrupts
// - writing the executing command entry sets the collision flag
// - abort flag sets when software clears queue enable
// - finished flag sets at end-of-queue command or after halt
// - in wraparound the finished flag sets on every end-of-queue pass
// - event flags clear on writing one, zero leaves them
// - ram holds 16 transmit, 16 receive and 16 command locations
// - data-window write stores at pointer then increments pointer
// - data-window read returns entry at pointer, increments, one wait state
// - pointer keeps counting past a section end, no wrap
// - command bytes use upper data byte; engine never writes them
// - hold-selects bit keeps selects asserted after transfer
// - width-select bit picks eight bits or mode size field
// - after-delay bit inserts the after-transfer delay
// - lead-delay bit picks half period or clock-lead delay field
// - command bits drive the four chip selects, any combination
// - pointer values 0x00, 0x10, 0x20 start the three sections
// - queue enable starts the queue and self-clears at end of queue unless wraparound is on
// - halt stops issuing commands after the current one ends
`default_nettype none
module qscr_top import qscr_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic access_error,
  output logic irq,
  output logic sck,
  output logic mosi,
  input wire logic miso,
  output logic [3:0] cs
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {Q_IDLE, Q_FETCH, Q_RUN, Q_HALT} qscr_q_state_t;
  typedef struct packed {
    qscr_q_state_t st;
    logic [15:0] mode;
    logic queue_enable;
    logic [6:0] lead;
    logic [7:0] after;
    logic halt;
    logic wren;
    logic wrto;
    logic select_inactive_level;
    logic [3:0] end_of_queue_pointer;
    logic [3:0] cptqp;
    logic [3:0] newqp;
    logic coll_berr;
    logic abort_berr;
    logic lockout;
    logic coll_ie;
    logic abort_ie;
    logic fin_ie;
    logic coll_f;
    logic abort_f;
    logic fin_f;
    logic [5:0] ptr;
    logic [3:0] qp;
    logic start;
    logic [3:0] cs;
    logic [15:0] rdata;
    logic berr;
    logic irq;
    logic miso_m;
    logic miso_s;
  } qscr_top_t;
  qscr_top_t q, d;
  // ----------------------------------------
  // ram and shift engine
  // ----------------------------------------
  logic [15:0] ram_rdata;
  logic [15:0] eng_tx;
  logic [7:0] eng_cmd;
  logic [15:0] rx_word;
  logic eng_done;
  logic busy;
  logic data_wr;
  logic coll;
  logic ram_we;
  qscr_xfer_t xfer;
  qscr_timing_t tim;
  assign busy = q.st != Q_IDLE;
  assign data_wr = reg_wr && reg_addr == OFF_DATA;
  // executing command lives at the command base plus the queue index
  assign coll = data_wr && busy && q.ptr == (CMD_BASE | {2'b00, q.qp});
  // a colliding write never lands, so the running entry stays intact
  assign ram_we = data_wr && !coll && q.ptr < RAM_END;
  assign xfer.tx = eng_tx;
  assign xfer.lead_en = eng_cmd[CMD_LEAD];
  assign xfer.after_en = eng_cmd[CMD_AFTER];
  always_comb begin
    if (!eng_cmd[CMD_WIDTH]) begin
      xfer.nbits = BYTE_BITS;
    end else if (q.mode[13:10] == 4'h0) begin
      xfer.nbits = WORD_BITS;
    end else begin
      xfer.nbits = {1'b0, q.mode[13:10]};
    end
  end
  assign tim.baud = q.mode[7:0];
  assign tim.cpol = q.mode[9];
  assign tim.cpha = q.mode[8];
  assign tim.lead = q.lead;
  assign tim.after = q.after;
  qscr_ram u_ram (
    .clk_sys(clk_sys),
    .rst(rst),
    .cpu_we(ram_we),
    .cpu_addr(q.ptr),
    .cpu_wdata(reg_wdata),
    .cpu_rdata(ram_rdata),
    .eng_idx(q.qp),
    .eng_tx(eng_tx),
    .eng_cmd(eng_cmd),
    .rx_we(eng_done),
    .rx_wdata(rx_word)
  );
  qscr_shift u_shift (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(q.start),
    .xfer(xfer),
    .tim(tim),
    .miso_s(q.miso_s),
    .sck(sck),
    .mosi(mosi),
    .done(eng_done),
    .rx_word(rx_word)
  );
  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic last;
  logic set_fin;
  logic set_abort;
  logic [3:0] wrap_qp;
  always_comb begin
    d = q;
    d.start = 1'b0;
    d.berr = 1'b0;
    d.miso_m = miso;
    d.miso_s = q.miso_m;
    set_fin = 1'b0;
    set_abort = 1'b0;
    last = q.qp == q.end_of_queue_pointer;
    wrap_qp = q.wrto ? q.newqp : 4'h0;
    // queue sequencer
    unique case (q.st)
      Q_IDLE: begin
        if (q.queue_enable && !q.halt) begin
          d.qp = q.newqp;
          d.st = Q_FETCH;
        end
      end
      Q_FETCH: begin
        // a zero divider holds the port disabled
        if (!q.queue_enable) begin
          d.st = Q_IDLE;
        end else if (q.mode[7:0] != 8'h00) begin
          d.start = 1'b1;
          d.cs = eng_cmd[3:0];
          d.st = Q_RUN;
        end
      end
      Q_RUN: begin
        if (eng_done) begin
          d.cptqp = q.qp;
          if (!eng_cmd[CMD_HOLD]) begin
            d.cs = {4{q.select_inactive_level}};
          end
          set_fin = last || q.halt;
          if (!q.queue_enable) begin
            d.st = Q_IDLE;
          end else if (last && !q.wren) begin
            d.queue_enable = 1'b0;
            d.st = Q_IDLE;
          end else begin
            d.qp = last ? wrap_qp : q.qp + 4'h1;
            d.st = q.halt ? Q_HALT : Q_FETCH;
          end
        end
      end
      Q_HALT: begin
        if (!q.queue_enable) begin
          d.st = Q_IDLE;
        end else if (!q.halt) begin
          d.st = Q_FETCH;
        end
      end
    endcase
    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        OFF_MODE: d.mode = reg_wdata;
        OFF_DELAY: begin
          if (reg_wdata[DLY_QUEUE_ENABLE]) begin
            d.queue_enable = 1'b1;
            d.lead = reg_wdata[14:8];
            d.after = reg_wdata[7:0];
          end else if (!q.queue_enable || q.lockout) begin
            d.lead = reg_wdata[14:8];
            d.after = reg_wdata[7:0];
          end else if (busy && q.abort_berr) begin
            d.berr = 1'b1;
          end else begin
            d.queue_enable = 1'b0;
            set_abort = 1'b1;
            d.lead = reg_wdata[14:8];
            d.after = reg_wdata[7:0];
          end
        end
        OFF_WRAP: begin
          d.halt = reg_wdata[WRAP_HALT];
          d.wren = reg_wdata[WRAP_WREN];
          d.wrto = reg_wdata[WRAP_WRTO];
          d.select_inactive_level = reg_wdata[WRAP_INACTIVE_LEVEL];
          d.end_of_queue_pointer = reg_wdata[11:8];
          d.newqp = reg_wdata[3:0];
        end
        OFF_EVENT: begin
          d.coll_berr = reg_wdata[EV_COLL_BERR];
          d.abort_berr = reg_wdata[EV_ABORT_BERR];
          d.lockout = reg_wdata[EV_LOCK];
          d.coll_ie = reg_wdata[EV_COLL_IE];
          d.abort_ie = reg_wdata[EV_ABORT_IE];
          d.fin_ie = reg_wdata[EV_FIN_IE];
        end
        OFF_PTR: d.ptr = reg_wdata[5:0];
        OFF_DATA: begin
          if (coll && q.coll_berr) begin
            d.berr = 1'b1;
          end else begin
            d.ptr = q.ptr + 6'h01;
          end
        end
        default: d.berr = 1'b0;
      endcase
    end
    // flags: write-one clears, a same-cycle set wins
    if (reg_wr && reg_addr == OFF_EVENT) begin
      d.coll_f = q.coll_f & ~reg_wdata[EV_COLL_F];
      d.abort_f = q.abort_f & ~reg_wdata[EV_ABORT_F];
      d.fin_f = q.fin_f & ~reg_wdata[EV_FIN_F];
    end
    d.coll_f = d.coll_f | coll;
    d.abort_f = d.abort_f | set_abort;
    d.fin_f = d.fin_f | set_fin;
    // register reads, data one cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_MODE: d.rdata = q.mode;
        OFF_DELAY: d.rdata = {q.queue_enable, q.lead, q.after};
        OFF_WRAP: d.rdata = {q.halt, q.wren, q.wrto, q.select_inactive_level,
                             q.end_of_queue_pointer, q.cptqp, q.newqp};
        OFF_EVENT: d.rdata = {q.coll_berr, q.abort_berr, 1'b0, q.lockout, q.coll_ie,
                              q.abort_ie, 1'b0, q.fin_ie, 4'h0, q.coll_f, q.abort_f,
                              1'b0, q.fin_f};
        OFF_PTR: d.rdata = {10'h000, q.ptr};
        OFF_DATA: begin
          d.rdata = ram_rdata;
          d.ptr = q.ptr + 6'h01;
        end
        default: d.rdata = 16'h0000;
      endcase
    end
    d.irq = (d.coll_f & d.coll_ie) | (d.abort_f & d.abort_ie) | (d.fin_f & d.fin_ie);
  end
  // ----------------------------------------
  // registers and outputs
  // ----------------------------------------
  assign reg_rdata = q.rdata;
  assign access_error = q.berr;
  assign irq = q.irq;
  assign cs = q.cs;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
      q.mode <= MODE_RST;
      {q.lead, q.after} <= DELAY_RST[14:0];
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/qscr_pkg.sv
`default_nettype none
package qscr_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_DELAY = 8'h04;
  localparam logic [7:0] OFF_WRAP = 8'h08;
  localparam logic [7:0] OFF_EVENT = 8'h0C;
  localparam logic [7:0] OFF_PTR = 8'h10;
  localparam logic [7:0] OFF_DATA = 8'h14;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int EV_COLL_BERR = 15;
  localparam int EV_ABORT_BERR = 14;
  localparam int EV_LOCK = 12;
  localparam int EV_COLL_IE = 11;
  localparam int EV_ABORT_IE = 10;
  localparam int EV_FIN_IE = 8;
  localparam int EV_COLL_F = 3;
  localparam int EV_ABORT_F = 2;
  localparam int EV_FIN_F = 0;
  localparam int DLY_QUEUE_ENABLE = 15;
  localparam int WRAP_HALT = 15;
  localparam int WRAP_WREN = 14;
  localparam int WRAP_WRTO = 13;
  localparam int WRAP_INACTIVE_LEVEL = 12;
  localparam int CMD_HOLD = 7;
  localparam int CMD_WIDTH = 6;
  localparam int CMD_AFTER = 5;
  localparam int CMD_LEAD = 4;
  // ----------------------------------------
  // ram sections and reset values
  // ----------------------------------------
  localparam logic [5:0] TX_BASE = 6'h00;
  localparam logic [5:0] RX_BASE = 6'h10;
  localparam logic [5:0] CMD_BASE = 6'h20;
  localparam logic [5:0] RAM_END = 6'h30;
  localparam logic [15:0] MODE_RST = 16'h0004;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] WORD_BITS = 5'h10;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] tx;
    logic [4:0] nbits;
    logic lead_en;
    logic after_en;
  } qscr_xfer_t;
  typedef struct packed {
    logic [7:0] baud;
    logic cpol;
    logic cpha;
    logic [6:0] lead;
    logic [7:0] after;
  } qscr_timing_t;
endpackage
`default_nettype wire

// ===== rtl/qscr_ram.sv
`default_nettype none
module qscr_ram import qscr_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cpu_we,
  input wire logic [5:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  input wire logic [3:0] eng_idx,
  output logic [15:0] eng_tx,
  output logic [7:0] eng_cmd,
  input wire logic rx_we,
  input wire logic [15:0] rx_wdata
);
  typedef struct packed {
    logic [15:0][15:0] tx;
    logic [15:0][15:0] rx;
    logic [15:0][7:0] cmd;
  } qscr_ram_t;
  qscr_ram_t q, d;
  logic [3:0] idx;
  assign idx = cpu_addr[3:0];
  always_comb begin
    d = q;
    if (cpu_we && cpu_addr < RX_BASE) begin
      d.tx[idx] = cpu_wdata;
    end else if (cpu_we && cpu_addr < CMD_BASE) begin
      d.rx[idx] = cpu_wdata;
    end else if (cpu_we && cpu_addr < RAM_END) begin
      d.cmd[idx] = cpu_wdata[15:8];
    end
    // engine only ever writes receive words
    if (rx_we) begin
      d.rx[eng_idx] = rx_wdata;
    end
  end
  always_comb begin
    if (cpu_addr < RX_BASE) begin
      cpu_rdata = q.tx[idx];
    end else if (cpu_addr < CMD_BASE) begin
      cpu_rdata = q.rx[idx];
    end else if (cpu_addr < RAM_END) begin
      cpu_rdata = {q.cmd[idx], 8'h00};
    end else begin
      cpu_rdata = 16'h0000;
    end
  end
  assign eng_tx = q.tx[eng_idx];
  assign eng_cmd = q.cmd[eng_idx];
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/qscr_shift.sv
`default_nettype none
module qscr_shift import qscr_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire qscr_xfer_t xfer,
  input wire qscr_timing_t tim,
  input wire logic miso_s,
  output logic sck,
  output logic mosi,
  output logic done,
  output logic [15:0] rx_word
);
  typedef enum logic [1:0] {SH_IDLE, SH_LEAD, SH_SHIFT, SH_TRAIL} qscr_sh_state_t;
  typedef struct packed {
    qscr_sh_state_t st;
    logic [7:0] cnt;
    logic [5:0] edges;
    logic [5:0] nedge;
    logic [15:0] txs;
    logic [15:0] rxs;
    logic sck;
    logic mosi;
    logic done;
  } qscr_sh_t;
  qscr_sh_t q, d;
  logic [15:0] aligned;
  logic leading;
  always_comb begin
    d = q;
    d.done = 1'b0;
    aligned = xfer.tx << (5'(WORD_BITS - xfer.nbits));
    leading = ~q.edges[0];
    unique case (q.st)
      SH_IDLE: begin
        d.sck = tim.cpol;
        if (start) begin
          d.st = SH_LEAD;
          d.edges = 6'h00;
          d.nedge = {xfer.nbits, 1'b0};
          d.rxs = 16'h0000;
          d.cnt = xfer.lead_en ? {1'b0, tim.lead} : tim.baud;
          d.txs = aligned;
          if (!tim.cpha) begin
            d.mosi = aligned[15];
            d.txs = aligned << 1;
          end
        end
      end
      SH_LEAD: begin
        d.cnt = q.cnt - 8'h01;
        if (q.cnt <= 8'h01) begin
          d.st = SH_SHIFT;
          d.cnt = tim.baud;
        end
      end
      SH_SHIFT: begin
        d.cnt = q.cnt - 8'h01;
        if (q.cnt <= 8'h01) begin
          d.cnt = tim.baud;
          d.sck = ~q.sck;
          d.edges = q.edges + 6'h01;
          // capture edge is leading for phase 0, trailing for phase 1
          if (leading ^ tim.cpha) begin
            d.rxs = {q.rxs[14:0], miso_s};
          end else begin
            d.mosi = q.txs[15];
            d.txs = q.txs << 1;
          end
          if (d.edges == q.nedge) begin
            d.st = SH_TRAIL;
            d.cnt = xfer.after_en ? tim.after : tim.baud;
          end
        end
      end
      SH_TRAIL: begin
        d.cnt = q.cnt - 8'h01;
        if (q.cnt <= 8'h01) begin
          d.st = SH_IDLE;
          d.done = 1'b1;
        end
      end
    endcase
  end
  assign sck = q.sck;
  assign mosi = q.mosi;
  assign done = q.done;
  assign rx_word = q.rxs;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// ===== dv/qscr_monitor.sv
`default_nettype none
module qscr_monitor import qscr_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic access_error,
  input wire logic irq,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic [3:0] cs
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_err_has_cause:
    assert property (access_error |-> $past(reg_wr) &&
      ($past(reg_addr) == OFF_DATA || $past(reg_addr) == OFF_DELAY))
    else $error("access error without a data or delay write");
  a_err_abort_clear:
    assert property (access_error && $past(reg_addr) == OFF_DELAY
      |-> !$past(reg_wdata[DLY_QUEUE_ENABLE]))
    else $error("access error on a delay write that sets enable");
  a_err_other_regs:
    assert property (reg_wr && reg_addr != OFF_DATA && reg_addr != OFF_DELAY |=> !access_error)
    else $error("access error on a plain register write");
  a_err_not_read:
    assert property (reg_rd |=> !access_error)
    else $error("access error after a read");
  a_rdata_hold:
    assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero:
    assert property (reg_rd && reg_addr > OFF_DATA |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_irq_disable:
    assert property (reg_wr && reg_addr == OFF_EVENT && reg_wdata[11:8] == 4'h0
      ##1 !(reg_wr && reg_addr == OFF_EVENT) |=> !irq)
    else $error("irq with all enables cleared");
  a_cs_stable_sck:
    assert property ($changed(sck) |-> $stable(cs))
    else $error("selects moved on a serial clock edge");
endmodule
bind qscr_top qscr_monitor u_qscr_monitor (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .access_error(access_error), .irq(irq), .sck(sck), .mosi(mosi), .miso(miso), .cs(cs));
`default_nettype wire

// ===== dv/qscr_peer.sv
`default_nettype none
module qscr_peer #(
  parameter logic [7:0] REPLY = 8'h3C
) (
  input wire logic [3:0] cs,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  wire sel = |cs;
  initial begin
    sh = REPLY;
    miso = 1'b0;
    got = 8'h00;
  end
  always @(posedge sel) begin
    sh = REPLY;
    miso = REPLY[7];
  end
  // released line shows the inverse, not a stale bit
  always @(negedge sel) miso = ~miso;
  always @(posedge sck) if (sel) got = {got[6:0], mosi};
  always @(negedge sck) if (sel) begin
    sh = {sh[6:0], 1'b0};
    miso = sh[7];
  end
endmodule
`default_nettype wire

// ===== dv/test_queued_serial_cmd_ram_control.sv
`default_nettype none
module test_queued_serial_cmd_ram_control;
  import qscr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, reg_wr, reg_rd, miso, access_error, irq, sck, mosi;
  logic seen_cs = 1'b0;
  logic [7:0] reg_addr, got;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic [3:0] cs;
  int bad_count = 0;
  int total_checks = 0;
  qscr_top u_qscr_top (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .access_error(access_error),
    .irq(irq), .sck(sck), .mosi(mosi), .miso(miso), .cs(cs));
  qscr_peer u_qscr_peer (.cs(cs), .sck(sck), .mosi(mosi), .miso(miso), .got(got));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (cs === 4'h5) seen_cs <= 1'b1;
  task automatic complete_run;
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] act, input logic [15:0] exp, input string what);
    total_checks++;
    if (act !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, act, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // polls until the masked bits match or 400 more reads pass; a long queue trades poll traffic for simplicity
  task automatic wait_bits(input logic [7:0] a, input logic [15:0] m, input logic [15:0] w);
    int n;
    n = 0;
    rd(a, v);
    while ((v & m) !== w && n < 400) begin
      rd(a, v);
      n++;
    end
    check(v & m, w, "wait for status");
  endtask
  task automatic try_abort(input logic [15:0] ev, input logic [15:0] e_err,
                           input logic [15:0] e_en, input logic [15:0] e_ev);
    wr(OFF_EVENT, ev);
    wr(OFF_DELAY, 16'h8000);
    repeat (20) @(posedge clk_sys);
    wr(OFF_DELAY, 16'h0000);
    check({15'h0, access_error}, e_err, "abort error");
    rd(OFF_DELAY, v);
    check(v & 16'h8000, e_en, "enable after clear");
    wait_bits(OFF_DELAY, 16'h8000, 16'h0000);
    rd(OFF_EVENT, v);
    check(v & 16'h0004, e_ev, "abort flag");
  endtask
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFF_MODE, v);
    check(v, MODE_RST, "mode reset");
    rd(OFF_EVENT, v);
    check(v, 16'h0000, "event reset");
    rd(OFF_PTR, v);
    check(v, 16'h0000, "pointer reset");
    rd(8'h18, v);
    check(v, 16'h0000, "unmapped read");
    wr(OFF_PTR, 16'h000F);
    wr(OFF_DATA, 16'hBEEF);
    wr(OFF_DATA, 16'h1234);
    rd(OFF_PTR, v);
    check(v, 16'h0011, "pointer after writes");
    wr(OFF_PTR, 16'h000F);
    rd(OFF_DATA, v);
    check(v, 16'hBEEF, "last tx word");
    rd(OFF_DATA, v);
    check(v, 16'h1234, "first rx word");
    rd(OFF_PTR, v);
    check(v, 16'h0011, "pointer after reads");
    // queue: entry 0 eight bits, entry 1 mode width with held selects
    wr(OFF_PTR, {10'h000, CMD_BASE});
    wr(OFF_DATA, 16'h05FF);
    wr(OFF_DATA, 16'hC500);
    wr(OFF_PTR, {10'h000, CMD_BASE});
    rd(OFF_DATA, v);
    check(v, 16'h0500, "command byte upper only");
    wr(OFF_PTR, {10'h000, TX_BASE});
    wr(OFF_DATA, 16'h00A5);
    wr(OFF_DATA, 16'h12A5);
    wr(OFF_WRAP, 16'h0100);
    wr(OFF_EVENT, 16'h0100);
    wr(OFF_DELAY, 16'h8000);
    wait_bits(OFF_EVENT, 16'h0001, 16'h0001);
    check({15'h0, irq}, 16'h0001, "finished irq");
    check({12'h0, cs}, 16'h0005, "selects held");
    check({15'h0, seen_cs}, 16'h0001, "selects driven");
    check({8'h00, got}, 16'h00A5, "serial out msb first");
    rd(OFF_DELAY, v);
    check(v & 16'h8000, 16'h0000, "enable self clear");
    wr(OFF_PTR, {10'h000, RX_BASE});
    rd(OFF_DATA, v);
    check(v & 16'h00FF, 16'h003C, "rx byte");
    rd(OFF_DATA, v);
    check(v, 16'h3C00, "rx word");
    wr(OFF_EVENT, 16'h0100);
    rd(OFF_EVENT, v);
    check(v & 16'h0001, 16'h0001, "zero write keeps flag");
    wr(OFF_EVENT, 16'h0000);
    rd(OFF_EVENT, v);
    check({15'h0, irq}, 16'h0000, "irq disabled");
    wr(OFF_EVENT, 16'h0101);
    rd(OFF_EVENT, v);
    check(v, 16'h0100, "flag cleared");
    try_abort(16'h400D, 16'h0001, 16'h8000, 16'h0000);
    try_abort(16'h100D, 16'h0000, 16'h8000, 16'h0000);
    try_abort(16'h040D, 16'h0000, 16'h0000, 16'h0004);
    check({15'h0, irq}, 16'h0001, "abort irq");
    wr(OFF_EVENT, 16'h800D);
    wr(OFF_DELAY, 16'h8000);
    repeat (20) @(posedge clk_sys);
    wr(OFF_PTR, {10'h000, CMD_BASE});
    wr(OFF_DATA, 16'h0F00);
    check({15'h0, access_error}, 16'h0001, "collision error");
    wait_bits(OFF_DELAY, 16'h8000, 16'h0000);
    rd(OFF_EVENT, v);
    check(v & 16'h0008, 16'h0008, "collision flag");
    wr(OFF_PTR, {10'h000, CMD_BASE});
    rd(OFF_DATA, v);
    check(v, 16'h0500, "command kept");
    // wraparound keeps finishing; halt parks the queue with enable still set
    wr(OFF_WRAP, 16'h4100);
    wr(OFF_EVENT, 16'h000D);
    wr(OFF_DELAY, 16'h8000);
    wait_bits(OFF_EVENT, 16'h0001, 16'h0001);
    wr(OFF_EVENT, 16'h0001);
    wait_bits(OFF_EVENT, 16'h0001, 16'h0001);
    wr(OFF_EVENT, 16'h0001);
    wr(OFF_WRAP, 16'hC100);
    wait_bits(OFF_EVENT, 16'h0001, 16'h0001);
    rd(OFF_DELAY, v);
    check(v & 16'h8000, 16'h8000, "enable kept in halt");
    wr(OFF_EVENT, 16'h0001);
    repeat (200) @(posedge clk_sys);
    rd(OFF_EVENT, v);
    check(v & 16'h0001, 16'h0000, "no entry after halt");
    wr(OFF_DELAY, 16'h0000);
    wr(OFF_WRAP, 16'h0000);
    complete_run();
  end
  initial begin
    #300000;
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
